//--- rtl/ddc_top.sv
/*
 Drum and display channel port: APB holds the host channel words, the core
 sequences drum transfers, autoload, watchdog and keyboard controls.
 Assumes drum timing logic gives index, sector and word-slot marks as pins.
*/
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
module ddc_top
  import ddc_pkg::*;
#(
  parameter int WDOG_CYCLES = 1700000,
  parameter int SEC_PER_TRK = 18
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drum
  input wire ddc_drum_in_s drum_in,
  output ddc_drum_out_s drum_out,
  // Panel and keyboard
  input wire ddc_panel_s panel,
  input wire logic [14:0] kb_lines,
  output ddc_kb_out_s kb_out,
  // Host halt and block transfer
  output logic host_halt,
  output ddc_bt_s bt
);
  localparam int SW = $bits(ddc_drum_in_s) + $bits(ddc_panel_s) + 15;

  if (WDOG_CYCLES < 2 || SEC_PER_TRK < 1 || SEC_PER_TRK > 32) begin : g_param_check
    $error("Unsupported parameter value.");
  end

  logic [SW-1:0] syn1, syn2;
  ddc_drum_in_s di, di_q;
  ddc_panel_s pn, pn_q;
  logic [14:0] kbs;
  logic [15:0] dout, ctl, aux, din, kbw;
  logic busy, op_wr, mode_q, cinh_q, cks_q, wlock_hit, seek_ok;
  logic [5:0] trk_q;
  logic [4:0] sec_q, scnt;
  logic [6:0] wrd_q, wpos;
  logic [15:0] data_q, sum;
  logic [12:0] tmo;
  logic [10:0] ald_cnt;
  logic wd_run;
  logic [31:0] wd_cnt;
  ddc_state_e st;

  // Every drum, panel and keyboard input passes two flops; edges are taken from the second stage.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syn1 <= '0;
      syn2 <= '0;
    end else if (ce) begin
      syn1 <= {drum_in, panel, kb_lines};
      syn2 <= syn1;
    end
  end
  assign {di, pn, kbs} = syn2;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      di_q <= '0;
      pn_q <= '0;
    end else if (ce) begin
      di_q <= di;
      pn_q <= pn;
    end
  end

  logic idx_e, sec_e, slot_e, ald_e;
  assign idx_e = di.index & ~di_q.index;
  assign sec_e = di.sector & ~di_q.sector;
  assign slot_e = di.slot & ~di_q.slot;
  assign ald_e = pn.ald_start & ~pn_q.ald_start;

  // APB: one wait state, then pready; writes take effect on the ready edge.
  logic acc, apb_wr, hit;
  assign acc = psel & penable & pready;
  assign apb_wr = acc & pwrite;
  assign hit = paddr == ADR_DOUT || paddr == ADR_CTL || paddr == ADR_AUX ||
               paddr == ADR_DIN || paddr == ADR_KBD || paddr == ADR_STAT;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata <= '0;
      if (psel & penable & ~pready & ~pwrite) begin
        case (paddr)
          ADR_DOUT: prdata <= {16'h0000, dout};
          ADR_CTL: prdata <= {16'h0000, ctl};
          ADR_AUX: prdata <= {16'h0000, aux};
          ADR_DIN: prdata <= {16'h0000, din};
          ADR_KBD: prdata <= {16'h0000, kbw};
          ADR_STAT: prdata <= {29'h0, host_halt, wlock_hit, busy};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // Requests are rising request bits; the host must hold its lines while busy.
  logic wreq_e, rreq_e, wd_strobe;
  assign wreq_e = apb_wr && paddr == ADR_CTL && pwdata[CTL_WREQ] && !ctl[CTL_WREQ];
  assign rreq_e = apb_wr && paddr == ADR_CTL && pwdata[CTL_RREQ] && !ctl[CTL_RREQ];
  assign wd_strobe = apb_wr && paddr == ADR_AUX && pwdata[AUX_WDOG];

  // Watchdog expiry clears the channel words and blocks further writes.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dout <= '0;
      ctl <= '0;
      aux <= '0;
    end else if (ce) begin
      if (host_halt) begin
        dout <= '0;
        ctl <= '0;
        aux <= '0;
      end else if (apb_wr) begin
        if (paddr == ADR_DOUT) begin
          dout <= pwdata[15:0];
        end
        if (paddr == ADR_CTL) begin
          ctl <= pwdata[15:0];
        end
        if (paddr == ADR_AUX) begin
          aux <= pwdata[15:0];
        end
      end
    end
  end

  // Watchdog: a set from the index mark wins over a strobe in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wd_run <= 1'b0;
      wd_cnt <= '0;
      host_halt <= 1'b0;
    end else if (ce) begin
      if (idx_e && (!wd_run || wd_strobe)) begin
        wd_run <= 1'b1;
        wd_cnt <= '0;
      end else if (wd_strobe) begin
        wd_run <= 1'b0;
      end else if (wd_run) begin
        wd_cnt <= wd_cnt + 32'h1;
        if (wd_cnt == 32'(WDOG_CYCLES - 1)) begin
          host_halt <= 1'b1;
        end
      end
    end
  end

  // Drum position: sector counted from index, word slot counted from sector mark.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scnt <= '0;
      wpos <= '0;
    end else if (ce) begin
      if (idx_e) begin
        scnt <= '0;
        wpos <= '0;
      end else if (sec_e) begin
        scnt <= scnt + 5'h1;
        wpos <= '0;
      end else if (slot_e) begin
        wpos <= wpos + 7'h1;
      end
    end
  end

  function automatic logic [11:0] next_addr(logic [4:0] s, logic [6:0] w, logic dm);
    logic [6:0] lim;
    lim = dm ? WORDS_DATA : WORDS_DISP;
    if (w == lim - 7'h1) begin
      next_addr = {(s == 5'(SEC_PER_TRK - 1)) ? 5'h0 : s + 5'h1, 7'h0};
    end else begin
      next_addr = {s, w + 7'h1};
    end
  endfunction

  function automatic logic [5:0] ald_track(logic [2:0] sel);
    ald_track = sel[2] ? ALD_HI_BASE + {4'h0, sel[1:0]} : {4'h0, sel[1:0]};
  endfunction

  logic blocked, match, tmo_hit, again;
  assign blocked = pn.wlock_sw && ctl[CTL_WREQ] == 1'b0 &&
                   aux[15:AUX_TRK] < WLOCK_TRACKS;
  assign match = cinh_q || (scnt == sec_q && wpos == wrd_q);
  assign tmo_hit = tmo == (mode_q ? 13'(TMO_DATA) : 13'(TMO_DISP));
  assign again = op_wr ? wreq_e : rreq_e;

  // Operation sequencer.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= ST_IDLE;
      busy <= 1'b0;
      op_wr <= 1'b0;
      mode_q <= 1'b0;
      cinh_q <= 1'b0;
      cks_q <= 1'b0;
      trk_q <= '0;
      sec_q <= '0;
      wrd_q <= '0;
      data_q <= '0;
      tmo <= '0;
      sum <= '0;
      ald_cnt <= '0;
      seek_ok <= 1'b0;
      wlock_hit <= 1'b0;
      din <= '0;
      drum_out <= '0;
      bt <= '0;
    end else if (ce) begin
      drum_out.wr_en <= 1'b0;
      bt.valid <= 1'b0;
      drum_out.trk <= trk_q;
      drum_out.sec <= sec_q;
      drum_out.wrd <= wrd_q;
      drum_out.gap_mode <= ~mode_q;
      drum_out.rd_en <= busy & ~op_wr;
      case (st)
        ST_IDLE: begin
          if (host_halt) begin
            st <= ST_IDLE;
          end else if (ald_e && pn.ald_local) begin
            trk_q <= ald_track(pn.ald_sel);
            sec_q <= '0;
            wrd_q <= '0;
            mode_q <= 1'b1;
            cinh_q <= 1'b0;
            ald_cnt <= '0;
            seek_ok <= 1'b0;
            busy <= 1'b1;
            st <= ST_ALD;
          end else if (wreq_e && blocked) begin
            wlock_hit <= 1'b1;
          end else if (wreq_e || rreq_e) begin
            op_wr <= wreq_e;
            mode_q <= pwdata[CTL_MODE];
            sec_q <= pwdata[CTL_CMARK-1:CTL_SEC];
            wrd_q <= pwdata[15:CTL_WRD];
            drum_out.cursor_odd <= pwdata[CTL_CMARK];
            trk_q <= aux[15:AUX_TRK];
            cinh_q <= aux[AUX_CINH];
            cks_q <= aux[AUX_CKS];
            data_q <= dout;
            sum <= '0;
            wlock_hit <= 1'b0;
            busy <= 1'b1;
            st <= ST_SEEK;
          end
        end
        ST_SEEK, ST_XFER: begin
          if (slot_e && (st == ST_XFER || match)) begin
            if (op_wr) begin
              drum_out.wr_en <= 1'b1;
              drum_out.wr_data <= data_q;
              sum <= sum + data_q;
            end else begin
              din <= di.rd;
              sum <= sum + di.rd;
            end
            {sec_q, wrd_q} <= next_addr(sec_q, wrd_q, mode_q);
            busy <= 1'b0;
            tmo <= '0;
            st <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (again) begin
            data_q <= dout;
            busy <= 1'b1;
            st <= ST_XFER;
          end else if (tmo_hit) begin
            st <= (op_wr && cks_q) ? ST_CKS : ST_IDLE;
            busy <= op_wr && cks_q;
          end else begin
            tmo <= tmo + 13'h1;
          end
        end
        ST_CKS: begin
          if (slot_e) begin
            drum_out.wr_en <= 1'b1;
            drum_out.wr_data <= sum;
            busy <= 1'b0;
            st <= ST_IDLE;
          end
        end
        ST_ALD: begin
          if (slot_e && (seek_ok || match)) begin
            seek_ok <= 1'b1;
            bt.valid <= 1'b1;
            bt.addr <= ald_cnt;
            bt.data <= di.rd;
            {sec_q, wrd_q} <= next_addr(sec_q, wrd_q, 1'b1);
            ald_cnt <= ald_cnt + 11'h1;
            if (ald_cnt == ALD_WORDS - 11'h1) begin
              busy <= 1'b0;
              st <= ST_IDLE;
            end
          end
        end
        default: begin
          st <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // Keyboard controls and lines; the halt forces lamp and buzzer on.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      kb_out <= '0;
      kbw <= '0;
    end else if (ce) begin
      kb_out.alert <= aux[AUX_ALERT] | host_halt;
      kb_out.buzz <= aux[AUX_BUZZ] | host_halt;
      kb_out.lockout <= aux[AUX_KLOCK] | pn.klock_sw;
      kbw <= {1'b0, kbs};
    end
  end

  a_busy_rises: assert property (@(posedge sys_clk) disable iff (rst)
    ce && st == ST_IDLE && rreq_e && !host_halt |=> busy && st == ST_SEEK)
    else $error("Busy did not rise on a read request.");
  a_wlock_blocks: assert property (@(posedge sys_clk) disable iff (rst)
    ce && st == ST_IDLE && wreq_e && blocked && !host_halt |=> !busy && wlock_hit)
    else $error("Locked track write was accepted.");
  a_kb_lockout: assert property (@(posedge sys_clk) disable iff (rst)
    ce && (aux[AUX_KLOCK] || pn.klock_sw) |=> kb_out.lockout)
    else $error("Keyboard lockout not shown.");
  a_mode_gap: assert property (@(posedge sys_clk) disable iff (rst)
    ce && st == ST_IDLE && wreq_e && !blocked && !host_halt ##1 ce
    |=> drum_out.gap_mode == !$past(mode_q))
    else $error("Gap mode does not follow the captured mode.");
  a_wd_halt: assert property (@(posedge sys_clk) disable iff (rst)
    ce && wd_run && !wd_strobe && wd_cnt == 32'(WDOG_CYCLES - 1) |=> host_halt ##1 ce
    |=> kb_out.alert && kb_out.buzz)
    else $error("Watchdog expiry did not halt and alert.");
  a_halt_clears: assert property (@(posedge sys_clk) disable iff (rst)
    ce && host_halt |=> ctl == 16'h0 && aux == 16'h0 && dout == 16'h0)
    else $error("Channel words not cleared on halt.");
  a_read_valid: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(busy) && st == ST_WAIT && !op_wr |-> din == $past(di.rd))
    else $error("Busy fell before read data was valid.");
  a_write_ends: assert property (@(posedge sys_clk) disable iff (rst)
    ce && st == ST_WAIT && tmo_hit && !again |=> st != ST_WAIT)
    else $error("Write did not end after the request timeout.");
  a_ald_range: assert property (@(posedge sys_clk) disable iff (rst)
    bt.valid |-> bt.addr < ALD_WORDS)
    else $error("Autoload address out of range.");
  a_apb_ready: assert property (@(posedge sys_clk) disable iff (rst)
    ce && psel && penable && !pready |=> pready ##1 (!ce || !pready))
    else $error("APB ready is not a single cycle.");

  c_write_word: cover property (@(posedge sys_clk) disable iff (rst) drum_out.wr_en);
  c_read_word: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(busy) && !op_wr);
  c_autoload: cover property (@(posedge sys_clk) disable iff (rst)
    st == ST_ALD ##1 st == ST_IDLE);
  c_halt: cover property (@(posedge sys_clk) disable iff (rst) $rose(host_halt));
endmodule

//--- shared/ddc_pkg.sv
/*
 Constants, types and register map of the drum and display channel port.
 Assumes one 100 MHz clock and an APB master holding the host channel words.
*/
// Contract
// - Control bit 0 picks mode: one is packed data, zero is display.
// - Host pulses control bit 2 when ready; logic supplies next drum word.
// - Sector comes from control bits 3 to 7.
// - Control bit 8 puts cursor under even (0) or odd (1) character.
// - Word position comes from control bits 9 to 15.
// - Auxiliary bit 0 enables a checksum word at record end.
// - Index starts watchdog, strobe clears it; expiry halts, clears, alerts.
// - Auxiliary bits 6 and 7 drive keyboard lamp and buzzer.
// - Keyboard lockout is auxiliary bit 8 or the panel switch.
// - Auxiliary bit 9 disables address compare; host controls transfer.
// - Track comes from auxiliary bits 10 to 15, one of 36.
// - Busy rises at each read, write or autoload; commands ignored meanwhile.
// - Write lockout switch blocks writes to the lowest 24 tracks.
// - Data mode records words back to back; sector of 64 words.
// - Display mode surrounds each word with six-character gaps.
// - Transfers start at the given address, then go consecutively.
// - Local autoload delivers 1152 track words over block transfer.
// - Panel picks autoload track 0, 1, 2, 3, 20, 21, 22 or 23; the logic gives 16 to 19 for the upper four.
// - Fifteen keyboard lines pass to the keyboard input word.
// - Data travels as 16-bit words in both directions.
// - Write ends unless re-requested within 14 us data, 24 us display.
// - On reads busy falls only once the word is valid.
package ddc_pkg;
  localparam logic [11:0] ADR_DOUT = 12'h000;
  localparam logic [11:0] ADR_CTL = 12'h004;
  localparam logic [11:0] ADR_AUX = 12'h008;
  localparam logic [11:0] ADR_DIN = 12'h00c;
  localparam logic [11:0] ADR_KBD = 12'h010;
  localparam logic [11:0] ADR_STAT = 12'h014;
  localparam int CTL_MODE = 0;
  localparam int CTL_WREQ = 1;
  localparam int CTL_RREQ = 2;
  localparam int CTL_SEC = 3;
  localparam int CTL_CMARK = 8;
  localparam int CTL_WRD = 9;
  localparam int AUX_CKS = 0;
  localparam int AUX_WDOG = 5;
  localparam int AUX_ALERT = 6;
  localparam int AUX_BUZZ = 7;
  localparam int AUX_KLOCK = 8;
  localparam int AUX_CINH = 9;
  localparam int AUX_TRK = 10;
  localparam int N_TRACKS = 36;
  localparam logic [5:0] WLOCK_TRACKS = 6'h18;
  localparam logic [6:0] WORDS_DATA = 7'h40;
  localparam logic [6:0] WORDS_DISP = 7'h24;
  localparam logic [10:0] ALD_WORDS = 11'h480;
  localparam logic [5:0] ALD_HI_BASE = 6'h10;
  localparam int GAP_CHARS = 6;
  localparam int CLK_MHZ = 100;
  localparam int T_REQ_DATA_NS = 14000;
  localparam int T_REQ_DISP_NS = 24000;
  localparam int TMO_DATA = T_REQ_DATA_NS * CLK_MHZ / 1000;
  localparam int TMO_DISP = T_REQ_DISP_NS * CLK_MHZ / 1000;
  typedef enum logic [2:0] {ST_IDLE, ST_SEEK, ST_XFER, ST_WAIT, ST_CKS, ST_ALD} ddc_state_e;
  typedef struct packed {
    logic index;
    logic sector;
    logic slot;
    logic [15:0] rd;
  } ddc_drum_in_s;
  typedef struct packed {
    logic wlock_sw;
    logic klock_sw;
    logic ald_start;
    logic ald_local;
    logic [2:0] ald_sel;
  } ddc_panel_s;
  typedef struct packed {
    logic [5:0] trk;
    logic [4:0] sec;
    logic [6:0] wrd;
    logic wr_en;
    logic rd_en;
    logic gap_mode;
    logic cursor_odd;
    logic [15:0] wr_data;
  } ddc_drum_out_s;
  typedef struct packed {
    logic alert;
    logic buzz;
    logic lockout;
  } ddc_kb_out_s;
  typedef struct packed {
    logic valid;
    logic [10:0] addr;
    logic [15:0] data;
  } ddc_bt_s;
endpackage

//--- tb/ddc_drum_model.sv
/*
 Drum timing model: word-slot, sector and index marks, and a read word per slot.
 Assumes the bench raises idx_en when index marks may reach the watchdog.
*/
`timescale 1ns/100ps
module ddc_drum_model
  import ddc_pkg::*;
#(
  parameter int SLOT_CYC = 64,
  parameter int WPS = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bench control
  input wire logic idx_en,
  // Drum marks and read word
  output ddc_drum_in_s drum_in
);
  int cyc;
  int wrd;
  int sec;
  logic mark;
  assign mark = (cyc == SLOT_CYC / 2) || (cyc == SLOT_CYC / 2 + 1);
  // Slots follow with no gap between them, so packed words sit back to back.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cyc <= 0;
      wrd <= 0;
      sec <= 0;
    end else begin
      cyc <= (cyc == SLOT_CYC - 1) ? 0 : cyc + 1;
      if (cyc == SLOT_CYC - 1) begin
        wrd <= (wrd == WPS - 1) ? 0 : wrd + 1;
        if (wrd == WPS - 1) begin
          sec <= (sec == 17) ? 0 : sec + 1;
        end
      end
    end
  end
  // The word changes half a slot before its mark, so it is stable across the sync delay.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drum_in <= '0;
    end else begin
      if (cyc == 0) begin
        drum_in.rd <= drum_in.rd * 16'h0d35 + 16'h1a2b;
      end
      drum_in.slot <= mark;
      drum_in.sector <= mark && wrd == 0;
      drum_in.index <= mark && wrd == 0 && sec == 0 && idx_en;
    end
  end
endmodule

//--- tb/tb.sv
/*
 Self-checking bench: APB host tasks, a queue of expected drum writes, and checks.
 Assumes the drum model supplies marks; autoload inputs are held idle.
*/
`timescale 1ns/100ps
module tb
  import ddc_pkg::*;
;
  logic sys_clk, rst, ce, psel, penable, pwrite, host_halt, pready, pslverr, idx_en, err_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [14:0] kb_lines;
  logic [35:0] exp_q[$];
  logic [15:0] last_rd, dat;
  logic [5:0] trk;
  logic [4:0] sec, f;
  logic [6:0] wrd;
  logic cur;
  ddc_drum_in_s drum_in;
  ddc_drum_out_s drum_out;
  ddc_panel_s panel;
  ddc_kb_out_s kb_out;
  ddc_bt_s bt;
  int errors, num_checks;

  ddc_top #(.WDOG_CYCLES(200), .SEC_PER_TRK(18)) dut (.sys_clk(sys_clk), .rst(rst),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drum_in(drum_in), .drum_out(drum_out), .panel(panel), .kb_lines(kb_lines),
    .kb_out(kb_out), .host_halt(host_halt), .bt(bt));
  ddc_drum_model drum (.sys_clk(sys_clk), .rst(rst), .idx_en(idx_en), .drum_in(drum_in));

  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    err_b = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) chk(1, 0, "apb hang");
  endtask

  function automatic logic [31:0] ctlw(input logic m, input logic rq, input logic [4:0] s,
                                        input logic c, input logic [6:0] w);
    return {16'h0, w, c, s, rq, 1'b0, m};
  endfunction

  function automatic logic [31:0] auxw(input logic [5:0] t, input logic [4:0] fl);
    return {16'h0, t, fl, 5'h0};
  endfunction

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(0, ADR_STAT, 0);
      n++;
    end while (rdat[0] !== 1'b0 && n < 100);
    chk(rdat[0], 0, "busy stuck");
  endtask

  // A request is a clear then a set of the request bit, fields held meanwhile.
  task automatic wr_word(input logic m, input logic [6:0] w, input logic ok);
    dat = 16'($urandom);
    apb(1, ADR_DOUT, {16'h0, dat});
    if (ok) exp_q.push_back({~m, cur, sec, trk, w, dat});
    apb(1, ADR_CTL, ctlw(m, 0, sec, cur, w));
    // Requesting just after a slot mark keeps the transfer clear of the busy probe.
    @(posedge drum_in.slot);
    apb(1, ADR_CTL, ctlw(m, 0, sec, cur, w) | 32'h2);
    apb(0, ADR_STAT, 0);
    if (ok) begin
      chk(rdat[0], 1, "busy rise");
      wait_idle();
    end else chk(rdat[1:0], 2'b10, "lockout");
  endtask

  task automatic wait_idx();
    int n;
    n = 0;
    while (drum_in.index !== 1'b1 && n < 6000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  always @(posedge drum_in.slot) last_rd = drum_in.rd;

  always @(posedge sys_clk) begin
    if (drum_out.wr_en === 1'b1) begin
      if (exp_q.size() == 0) chk(1, 0, "unexpected write");
      else chk({drum_out.gap_mode, drum_out.cursor_odd, drum_out.sec, drum_out.trk,
                drum_out.wrd, drum_out.wr_data}, exp_q.pop_front(), "drum write");
    end
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    $display("[ERR] %0t timeout", $time);
    print_verdict();
  end

  initial begin
    rst = 1;
    ce = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    kb_lines = 0;
    panel = '0;
    idx_en = 0;
    errors = 0;
    num_checks = 0;
    cur = 0;
    void'($urandom(32'h0678));
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    kb_lines <= 15'($urandom);
    f = 5'($urandom) & 5'h0e;
    apb(1, ADR_AUX, auxw(6'h0, f));
    repeat (4) @(posedge sys_clk);
    apb(0, ADR_KBD, 0);
    chk(rdat, {17'h0, kb_lines}, "keyboard lines");
    chk(kb_out, {f[1], f[2], f[3]}, "keyboard controls");
    panel.klock_sw <= 1;
    repeat (4) @(posedge sys_clk);
    chk(kb_out.lockout, 1, "panel lockout");
    apb(0, 12'h01c, 0);
    chk(err_b, 1, "unmapped");
    $display("test keyboard done");
    for (int m = 0; m < 2; m++) begin
      trk = 6'h18 + 6'($urandom_range(11));
      sec = 5'($urandom_range(17));
      wrd = 7'($urandom_range(31));
      cur = 1'($urandom);
      apb(1, ADR_AUX, auxw(trk, 5'h10));
      wr_word(m[0], wrd, 1);
      wr_word(m[0], wrd + 7'h1, 1);
      apb(1, ADR_CTL, ctlw(m[0], 1, sec, cur, wrd + 7'h1) | 32'h2);
      apb(0, ADR_STAT, 0);
      chk(rdat[0], 0, "read refused mid write");
      repeat (2500) @(posedge sys_clk);
    end
    $display("test writes done");
    panel.wlock_sw <= 1;
    trk = 6'($urandom_range(23));
    apb(1, ADR_AUX, auxw(trk, 5'h10));
    wr_word(1, wrd, 0);
    trk = 6'h18;
    apb(1, ADR_AUX, auxw(trk, 5'h10) | 32'h1);
    wr_word(1, wrd, 1);
    exp_q.push_back({1'b0, cur, sec, trk, wrd + 7'h1, dat});
    repeat (1600) @(posedge sys_clk);
    panel.wlock_sw <= 0;
    $display("test lockout done");
    apb(1, ADR_AUX, auxw(6'h1a, 5'h10));
    apb(1, ADR_CTL, ctlw(1, 0, sec, 0, wrd));
    @(posedge drum_in.slot);
    apb(1, ADR_CTL, ctlw(1, 1, sec, 0, wrd));
    apb(0, ADR_STAT, 0);
    chk({rdat[0], drum_out.rd_en}, 2'b11, "read busy");
    wait_idle();
    apb(0, ADR_DIN, 0);
    chk(rdat, {16'h0, last_rd}, "read word");
    repeat (1500) @(posedge sys_clk);
    $display("test read done");
    idx_en <= 1;
    wait_idx();
    apb(1, ADR_AUX, 32'h20);
    repeat (250) @(posedge sys_clk);
    chk(host_halt, 0, "strobe clears");
    wait_idx();
    repeat (260) @(posedge sys_clk);
    chk({host_halt, kb_out.alert, kb_out.buzz}, 3'b111, "watchdog expiry");
    apb(1, ADR_AUX, 32'h40);
    apb(0, ADR_AUX, 0);
    chk(rdat, 0, "halted write dropped");
    chk(kb_out.alert, 1, "halt holds alert");
    chk(exp_q.size(), 0, "writes missing");
    $display("test watchdog done");
    print_verdict();
  end
endmodule
